// file: design/svm_pkg.sv
// Constants shared by the system voltage monitor logic.
package sysmon_pkg;

  // Register map and field layout of supply_monitor_control.
  localparam logic [7:0] SMC_ADDR      = 8'h19;
  localparam int         LOW_BIT       = 0;
  localparam int         LVL_LSB       = 1;
  localparam int         LVL_MSB       = 3;
  localparam int         DISDB_BIT     = 4;
  localparam int         RSVD_LSB      = 5;
  localparam int         RSVD_MSB      = 7;
  localparam logic [2:0] LVL_NA        = 3'h0;
  localparam logic [2:0] LVL_RESET     = 3'h1;
  localparam logic       DISDB_RESET   = 1'b0;
  localparam logic [7:0] RDATA_RESET   = 8'h00;

  // Timing, counted in periods of the 32.768 kHz oscillator.
  localparam int OSC_HZ          = 32768;
  localparam int DEB_MS          = 62;
  localparam int DEB_TICKS       = (DEB_MS * OSC_HZ + 999) / 1000;
  localparam int SAVE_TIMEOUT_S  = 8;
  localparam int SAVE_TICKS      = SAVE_TIMEOUT_S * OSC_HZ;
  localparam int DEB_W           = 12;
  localparam int SAVE_W          = 20;

  // Save-timeout supervisor states.
  typedef enum logic [1:0] {
    SUP_IDLE,
    SUP_WAIT,
    SUP_FORCED
  } sup_state_t;

endpackage

// file: design/svm_debounce.sv
// Rising-edge debounce filter for the low-supply indication.
`timescale 1ns/1ps
module low_debounce
  import sysmon_pkg::*;
#(
  parameter int DEB_COUNT = DEB_TICKS
)
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic tick,
  input  wire logic bypass,
  input  wire logic raw_low,
  output logic      filt_low
);

  logic [DEB_W-1:0] cnt;
  logic [DEB_W-1:0] next_cnt;
  logic             next_filt_low;

  always_comb
  begin
    next_cnt      = cnt;
    next_filt_low = filt_low;
    if (!raw_low)
    begin
      // Recovery passes at once and the count restarts.
      next_cnt      = '0;
      next_filt_low = 1'b0;
    end
    else if (bypass)
    begin
      next_filt_low = 1'b1;
    end
    else if (tick && !filt_low)
    begin
      if (cnt == DEB_W'(DEB_COUNT - 1))
        next_filt_low = 1'b1;
      else
        next_cnt = cnt + DEB_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt      <= '0;
      filt_low <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt      <= next_cnt;
      filt_low <= next_filt_low;
    end
  end

endmodule

// file: design/system_voltage_monitor_logic.sv
// System voltage monitor: threshold select, debounce, status, interrupt and save timeout.
//
// Contract
// - Threshold select bits 3..1; 001 is 2.80 V, +100 mV per code to 111.
// - Bit 0 is a read-only flag, 1 when supply is below threshold.
// - System-ok status stays 1 while supply is above threshold.
// - Falling below threshold raises the low-system interrupt and clears system-ok.
// - With debounce on, low must persist 62 ms before it takes effect.
// - Recovery from low passes at once, without debounce.
// - Bit 4 set bypasses the debounce, clear applies it; resets to 0.
// - Debounce interval stays within five percent of nominal.
// - No save within 8 s of the interrupt forces save through on/off control.
// - Control register resets only in no-power state; threshold reset per variant.
// - Monitor always runs under on/off control; software cannot disable it.
// - Control register sits at address 19h; bits 7..5 reserved.
// - Registers reached by the host over the serial bus; monitor cannot be disabled.
`timescale 1ns/1ps
module system_voltage_monitor_logic
  import sysmon_pkg::*;
#(
  parameter logic [2:0] LVL_DEFAULT  = LVL_RESET,
  parameter int         DEB_COUNT    = DEB_TICKS,
  parameter int         SAVE_COUNT   = SAVE_TICKS
)
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic       osc32k,
  input  wire logic       sys_below_raw,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       save_entered,
  output logic      [7:0] reg_rdata,
  output logic      [2:0] threshold_sel,
  output logic            sysok,
  output logic            lowsys_irq,
  output logic            force_save
);

  // Synchronisers for the oscillator and the comparator pin.
  logic       osc_s1;
  logic       osc_s2;
  logic       osc_d;
  logic       low_s1;
  logic       low_s2;
  logic       tick;
  logic       low_flag;
  logic       low_prev;

  // Register state.
  logic [2:0] lvl;
  logic       disdb;
  logic [2:0] next_lvl;
  logic       next_disdb;
  logic [7:0] next_rdata;
  logic       next_irq;
  logic       hit;

  // Supervisor state.
  sup_state_t        state;
  sup_state_t        next_state;
  logic [SAVE_W-1:0] save_cnt;
  logic [SAVE_W-1:0] next_save_cnt;
  logic              next_force;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_d  <= 1'b0;
      low_s1 <= 1'b0;
      low_s2 <= 1'b0;
    end
    else if (clk_en)
    begin
      osc_s1 <= osc32k;
      osc_s2 <= osc_s1;
      osc_d  <= osc_s2;
      low_s1 <= sys_below_raw;
      low_s2 <= low_s1;
    end
  end

  assign tick = osc_s2 & ~osc_d;

  // The filter runs on clk_en; of the register bits, only the bypass bit reaches it.
  low_debounce #(
    .DEB_COUNT (DEB_COUNT)
  ) u_debounce (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .tick     (tick),
    .bypass   (disdb),
    .raw_low  (low_s2),
    .filt_low (low_flag)
  );

  assign hit           = (reg_addr == SMC_ADDR);
  assign threshold_sel = lvl;
  assign sysok         = ~low_flag;

  always_comb
  begin
    next_lvl   = lvl;
    next_disdb = disdb;
    next_rdata = RDATA_RESET;
    if (reg_wr && hit)
    begin
      next_lvl   = reg_wdata[LVL_MSB:LVL_LSB];
      next_disdb = reg_wdata[DISDB_BIT];
    end
    if (reg_rd && hit)
    begin
      next_rdata[LOW_BIT]         = low_flag;
      next_rdata[LVL_MSB:LVL_LSB] = lvl;
      next_rdata[DISDB_BIT]       = disdb;
    end
    next_irq = low_flag & ~low_prev;
  end

  // The async reset stands for the no-power state only.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lvl        <= LVL_DEFAULT;
      disdb      <= DISDB_RESET;
      reg_rdata  <= RDATA_RESET;
      low_prev   <= 1'b0;
      lowsys_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      lvl        <= next_lvl;
      disdb      <= next_disdb;
      reg_rdata  <= next_rdata;
      low_prev   <= low_flag;
      lowsys_irq <= next_irq;
    end
  end

  // Supervisor: a save request from the host ends the wait; otherwise the
  // timeout forces save. A later interrupt during the wait does not restart it,
  // so the 8 s figure counts from the first unanswered interrupt.
  always_comb
  begin
    next_state    = state;
    next_save_cnt = save_cnt;
    next_force    = 1'b0;
    case (state)
      SUP_IDLE:
      begin
        next_save_cnt = '0;
        if (lowsys_irq && !save_entered)
          next_state = SUP_WAIT;
      end
      SUP_WAIT:
      begin
        if (save_entered)
        begin
          next_state = SUP_IDLE;
        end
        else if (tick)
        begin
          if (save_cnt == SAVE_W'(SAVE_COUNT - 1))
          begin
            next_force = 1'b1;
            next_state = SUP_FORCED;
          end
          else
          begin
            next_save_cnt = save_cnt + SAVE_W'(1);
          end
        end
      end
      SUP_FORCED:
      begin
        if (save_entered)
          next_state = SUP_IDLE;
      end
      default:
      begin
        next_state = SUP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state      <= SUP_IDLE;
      save_cnt   <= '0;
      force_save <= 1'b0;
    end
    else if (clk_en)
    begin
      state      <= next_state;
      save_cnt   <= next_save_cnt;
      force_save <= next_force;
    end
  end

  // Helper for checks: oscillator ticks seen while the synced low stays set.
  logic [DEB_W-1:0] tick_run;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tick_run <= '0;
    else if (clk_en)
    begin
      if (!low_s2)
        tick_run <= '0;
      else if (tick && tick_run != '1)
        tick_run <= tick_run + DEB_W'(1);
    end
  end

  property p_lvl_write;
    clk_en && reg_wr && hit |=> threshold_sel == $past(reg_wdata[LVL_MSB:LVL_LSB]);
  endproperty
  a_lvl_write: assert property (p_lvl_write) else $error("threshold not written");

  property p_read_flag;
    clk_en && reg_rd && hit |=> reg_rdata[LOW_BIT] == $past(low_flag);
  endproperty
  a_read_flag: assert property (p_read_flag) else $error("low flag read wrong");

  property p_sysok;
    clk_en && !low_s2 |=> sysok;
  endproperty
  a_sysok: assert property (p_sysok) else $error("sysok low while supply ok");

  property p_irq;
    // A low that has already gone away may set sysok again, so only a held low is checked.
    clk_en && $rose(low_flag) && low_s2 |=> lowsys_irq && !sysok;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt on low supply");

  property p_debounce;
    $rose(low_flag) && !$past(disdb) |-> $past(tick_run) >= DEB_W'(DEB_COUNT - 1);
  endproperty
  a_debounce: assert property (p_debounce) else $error("low passed too early");

  property p_fall;
    clk_en && !low_s2 |=> !low_flag;
  endproperty
  a_fall: assert property (p_fall) else $error("recovery delayed");

  property p_bypass;
    clk_en && disdb && low_s2 |=> low_flag;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not honoured");

  property p_force;
    $rose(force_save) |-> $past(save_cnt) == SAVE_W'(SAVE_COUNT - 1);
  endproperty
  a_force: assert property (p_force) else $error("forced save at wrong time");

  property p_rsvd;
    clk_en && reg_rd |=> reg_rdata[RSVD_MSB:RSVD_LSB] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  property p_miss_read;
    clk_en && reg_rd && !hit |=> reg_rdata == RDATA_RESET;
  endproperty
  a_miss_read: assert property (p_miss_read) else $error("foreign read not zero");

  property p_force_pulse;
    clk_en && force_save |=> !force_save;
  endproperty
  a_force_pulse: assert property (p_force_pulse) else $error("forced save held");

  c_irq:    cover property (lowsys_irq);
  c_force:  cover property (force_save);
  c_bypass: cover property (disdb && $rose(low_flag));

endmodule

// file: test/host_model.sv
// Host model that reports the save state shortly after a low-supply or forced event.
`timescale 1ns/1ps
module host_model
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic serve,
  input  wire logic lowsys_irq,
  input  wire logic force_save,
  output logic      save_entered
);
  logic       pending;
  logic [3:0] cnt;

  // A host that is not serving stays silent, which lets the save timeout run out.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pending      <= 1'b0;
      cnt          <= 4'h0;
      save_entered <= 1'b0;
    end
    else if (lowsys_irq || force_save)
      pending <= 1'b1;
    else if (pending && serve)
    begin
      cnt          <= cnt + 4'h1;
      save_entered <= (cnt >= 4'h6);
      if (cnt == 4'hA)
      begin
        pending <= 1'b0;
        cnt     <= 4'h0;
      end
    end
    else
      save_entered <= 1'b0;
  end
endmodule

// file: test/testbench.sv
// Self-checking bench for the system voltage monitor logic.
`timescale 1ns/1ps
module testbench;
  import sysmon_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn  = 1'b0;
  logic       osc32k  = 1'b0;
  logic       raw     = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic       serve   = 1'b0;
  logic [2:0] div     = 3'h0;
  logic       save_entered;
  logic [7:0] rdata;
  logic [2:0] sel;
  logic       sysok;
  logic       irq;
  logic       force_save;
  logic [7:0] v;
  int         fails = 0;
  int         check_count = 0;
  int         n;

  always #12.5 ref_clk = ~ref_clk;

  // A fast stand-in for the slow oscillator keeps the long counts short.
  always @(negedge ref_clk)
  begin
    div    <= div + 3'h1;
    osc32k <= div[2];
  end

  system_voltage_monitor_logic #(.DEB_COUNT(4), .SAVE_COUNT(8)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .osc32k(osc32k),
    .sys_below_raw(raw), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .save_entered(save_entered), .reg_rdata(rdata),
    .threshold_sel(sel), .sysok(sysok), .lowsys_irq(irq), .force_save(force_save));

  host_model i_host (.ref_clk(ref_clk), .resetn(resetn), .serve(serve),
    .lowsys_irq(irq), .force_save(force_save), .save_entered(save_entered));

  task automatic final_report();
    $display("Checks %0d, errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge ref_clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    rd   = 1'b1;
    @(negedge ref_clk);
    d  = rdata;
    rd = 1'b0;
  endtask

  // Counts falling edges until sysok drops, or until force_save pulses.
  task automatic wait_on(input logic frc, output int cnt);
    cnt = 0;
    while ((frc ? force_save : ~sysok) !== 1'b1)
    begin
      @(negedge ref_clk);
      cnt++;
      if (cnt > 300)
      begin
        fails++;
        $display("Error at %0t: wait expired", $time);
        final_report();
      end
    end
  endtask

  task automatic t_reset();
    rd_reg(SMC_ADDR, v);
    chk(v, {4'h0, LVL_RESET, 1'b0});
    chk({5'h0, sel}, {5'h0, LVL_RESET});
    chk({7'h0, sysok}, 8'h01);
  endtask

  task automatic t_codes();
    for (int c = 1; c < 8; c++)
    begin
      wr_reg(SMC_ADDR, {3'h7, 1'b0, c[2:0], 1'b1});
      chk({5'h0, sel}, c[7:0]);
      rd_reg(SMC_ADDR, v);
      chk(v, {4'h0, c[2:0], 1'b0});
    end
    wr_reg(8'h18, 8'h00);
    rd_reg(8'h18, v);
    chk(v, 8'h00);
    chk({5'h0, sel}, 8'h07);
  endtask

  task automatic t_bypass();
    wr_reg(SMC_ADDR, 8'h13);
    rd_reg(SMC_ADDR, v);
    chk(v, 8'h12);
    raw = 1'b1;
    wait_on(1'b0, n);
    chk({7'h0, n >= 2 && n <= 5}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    @(negedge ref_clk);
    chk({7'h0, irq}, 8'h01);
    @(negedge ref_clk);
    chk({7'h0, irq}, 8'h00);
    wait_on(1'b1, n);
    chk({7'h0, n >= 45 && n <= 75}, 8'h01);
    @(negedge ref_clk);
    chk({7'h0, force_save}, 8'h00);
    rd_reg(SMC_ADDR, v);
    chk(v, 8'h13);
    raw = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({7'h0, sysok}, 8'h01);
    rd_reg(SMC_ADDR, v);
    chk(v, 8'h12);
    serve = 1'b1;
    repeat (20) @(negedge ref_clk);
  endtask

  task automatic t_debounce();
    wr_reg(SMC_ADDR, 8'h0E);
    raw = 1'b1;
    repeat (16) @(negedge ref_clk);
    raw = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk({7'h0, sysok}, 8'h01);
    raw = 1'b1;
    wait_on(1'b0, n);
    chk({7'h0, n >= 22 && n <= 40}, 8'h01);
    raw = 1'b0;
    n   = 0;
    repeat (100)
    begin
      @(negedge ref_clk);
      if (force_save !== 1'b0)
        n++;
    end
    chk(n[7:0], 8'h00);
  endtask

  initial
  begin
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    t_reset();
    t_codes();
    t_bypass();
    t_debounce();
    final_report();
  end
endmodule
